// >>> src/wkt_params.svh
/*
  Register offsets, field positions and reset values of the wake-up timer.
  Assumes an 8-bit register port with 8-bit addresses in the host interface.
*/
`ifndef WKT_PARAMS_SVH
`define WKT_PARAMS_SVH
`define WKT_ADDR_CONTROL      8'h23
`define WKT_ADDR_RELOAD_HIGH  8'h24
`define WKT_ADDR_RELOAD_LOW   8'h25
`define WKT_ADDR_COUNT_HIGH   8'h26
`define WKT_ADDR_COUNT_LOW    8'h27
`define WKT_BIT_ACTIVE        7
`define WKT_BIT_RUN_STROBE    6
`define WKT_BIT_TRIM_EN       5
`define WKT_BIT_DETECT_EN     4
`define WKT_BIT_RELOAD_EN     3
`define WKT_BIT_WAKE_EN       2
`define WKT_CONTROL_RESET     6'h00
`define WKT_RELOAD_RESET      16'h0000
`define WKT_DIV_8             6'h07
`define WKT_DIV_16            6'h0F
`define WKT_DIV_32            6'h1F
`endif

// >>> src/wkt_pkg.sv
/*
  Types shared by the wake-up timer.
  Assumes the params header is compiled alongside.
*/
package wkt_pkg;
  typedef enum logic [1:0] {
    WKT_TICK_DIV1,
    WKT_TICK_DIV8,
    WKT_TICK_DIV16,
    WKT_TICK_DIV32
  } wkt_tick_sel_t;

  typedef struct packed {
    logic          trim_en;
    logic          detect_en;
    logic          reload_en;
    logic          wake_en;
    wkt_tick_sel_t tick_sel;
  } wkt_ctrl_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wkt_bus_req_t;
endpackage : wkt_pkg

// >>> src/wkt_timer.sv
/*
  Wake-up timer: 16-bit down counter on the slow oscillator with prescaler,
  reload, wake, trimming and card-detection launch.
  Assumes a synchronous 8-bit register port from the host interface logic,
  an asynchronous slow oscillator level on a pin, and handshakes with the
  trimming and card-detection sequencers elsewhere in the device.
*/
`timescale 1ns/1ns
`include "wkt_params.svh"
module wkt_timer #(
  parameter int CNT_W = 16
) (
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  input  wire wkt_pkg::wkt_bus_req_t bus_in,
  output logic [7:0]             rdata_out,
  input  wire logic              slow_osc_in,
  input  wire logic              detect_done_in,
  input  wire logic              card_found_in,
  output logic                   wake_system_out,
  output logic                   irq_flag_out,
  output logic                   trim_start_out,
  output logic                   detect_start_out,
  output logic                   field_window_start_out,
  output logic                   card_irq_out,
  output logic                   power_down_out,
  output logic                   active_out
);
  import wkt_pkg::*;

  wkt_ctrl_t        ctrl_q;
  logic             active_q;
  logic [CNT_W-1:0] reload_q;
  logic [CNT_W-1:0] count_q;
  logic [2:0]       osc_sync_q;
  logic             osc_seen_q;
  logic [5:0]       div_q;
  logic             osc_edge;
  logic             tick;
  logic             underflow;
  logic             ctrl_wr;
  logic             start_evt;
  logic             stop_evt;

  function automatic logic [5:0] div_limit(input wkt_tick_sel_t sel);
    case (sel)
      WKT_TICK_DIV8:  div_limit = `WKT_DIV_8;
      WKT_TICK_DIV16: div_limit = `WKT_DIV_16;
      WKT_TICK_DIV32: div_limit = `WKT_DIV_32;
      default:        div_limit = 6'h00;
    endcase
  endfunction : div_limit

  assign ctrl_wr = bus_in.wr && (bus_in.addr == `WKT_ADDR_CONTROL);
  assign start_evt = ctrl_wr && bus_in.wdata[`WKT_BIT_RUN_STROBE]
                     && bus_in.wdata[`WKT_BIT_ACTIVE];
  assign stop_evt  = ctrl_wr && bus_in.wdata[`WKT_BIT_RUN_STROBE]
                     && !bus_in.wdata[`WKT_BIT_ACTIVE];

  // Pin synchroniser
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_sync_q <= 3'h0;
      osc_seen_q <= 1'b0;
    end else begin
      osc_sync_q <= {osc_sync_q[1:0], slow_osc_in};
      if (osc_sync_q[2] == osc_sync_q[1]) begin
        osc_seen_q <= osc_sync_q[1];
      end
    end
  end
  assign osc_edge = (osc_sync_q[2] == osc_sync_q[1]) && osc_sync_q[1] && !osc_seen_q;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_q <= 6'h00;
    end else if (start_evt || !active_q) begin
      div_q <= 6'h00;
    end else if (osc_edge) begin
      div_q <= (div_q >= div_limit(ctrl_q.tick_sel)) ? 6'h00 : div_q + 6'h01;
    end
  end
  assign tick = active_q && osc_edge && (div_q >= div_limit(ctrl_q.tick_sel));
  assign underflow = tick && (count_q == '0);

  // Control register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_q <= wkt_ctrl_t'(`WKT_CONTROL_RESET);
    end else if (ctrl_wr) begin
      ctrl_q <= wkt_ctrl_t'(bus_in.wdata[5:0]);
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reload_q <= `WKT_RELOAD_RESET;
    end else if (bus_in.wr && bus_in.addr == `WKT_ADDR_RELOAD_HIGH) begin
      reload_q[15:8] <= bus_in.wdata;
    end else if (bus_in.wr && bus_in.addr == `WKT_ADDR_RELOAD_LOW) begin
      reload_q[7:0] <= bus_in.wdata;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      active_q <= 1'b0;
    end else if (start_evt) begin
      active_q <= 1'b1;
    end else if (stop_evt) begin
      active_q <= 1'b0;
    end else if (underflow && !ctrl_q.reload_en && !ctrl_q.detect_en) begin
      active_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_q <= '0;
    end else if (start_evt) begin
      count_q <= reload_q;
    end else if (underflow && (ctrl_q.reload_en || ctrl_q.detect_en)) begin
      count_q <= reload_q;
    end else if (tick && count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_flag_out <= 1'b0;
    end else if (underflow) begin
      irq_flag_out <= 1'b1;
    end
  end

  // Launch pulses
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trim_start_out         <= 1'b0;
      detect_start_out       <= 1'b0;
      field_window_start_out <= 1'b0;
      wake_system_out        <= 1'b0;
    end else begin
      trim_start_out         <= underflow && ctrl_q.trim_en;
      detect_start_out       <= underflow && ctrl_q.detect_en;
      field_window_start_out <= underflow && ctrl_q.detect_en;
      wake_system_out        <= underflow && ctrl_q.wake_en;
    end
  end

  // Detection outcome
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      card_irq_out   <= 1'b0;
      power_down_out <= 1'b0;
    end else begin
      card_irq_out   <= detect_done_in && card_found_in;
      power_down_out <= detect_done_in && !card_found_in && ctrl_q.wake_en;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 8'h00;
    end else if (bus_in.rd) begin
      if (bus_in.addr == `WKT_ADDR_CONTROL) begin
        rdata_out <= {active_q, 1'b0, ctrl_q};
      end else if (bus_in.addr == `WKT_ADDR_RELOAD_HIGH) begin
        rdata_out <= reload_q[15:8];
      end else if (bus_in.addr == `WKT_ADDR_RELOAD_LOW) begin
        rdata_out <= reload_q[7:0];
      end else if (bus_in.addr == `WKT_ADDR_COUNT_HIGH) begin
        rdata_out <= count_q[15:8];
      end else if (bus_in.addr == `WKT_ADDR_COUNT_LOW) begin
        rdata_out <= count_q[7:0];
      end else begin
        rdata_out <= 8'h00;
      end
    end
  end

  assign active_out = active_q;
endmodule : wkt_timer

// >>> test/wkt_timer_assertions.sv
/* Port checker for wkt_timer.
   Assumes it is bound to every wkt_timer instance. */
`timescale 1ns/1ns
module wkt_timer_assertions #(parameter int CNT_W = 16) (
  input wire logic                  clk_in,
  input wire logic                  nrst_in,
  input wire wkt_pkg::wkt_bus_req_t bus_in,
  input wire logic [7:0]            rdata_out,
  input wire logic                  slow_osc_in,
  input wire logic                  detect_done_in,
  input wire logic                  card_found_in,
  input wire logic                  wake_system_out,
  input wire logic                  irq_flag_out,
  input wire logic                  trim_start_out,
  input wire logic                  detect_start_out,
  input wire logic                  field_window_start_out,
  input wire logic                  card_irq_out,
  input wire logic                  power_down_out,
  input wire logic                  active_out
);
  import wkt_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence ctrl_rd; bus_in.rd && bus_in.addr == 8'h23; endsequence
  sequence bad_rd; bus_in.rd && (bus_in.addr < 8'h23 || bus_in.addr > 8'h27); endsequence
  window_sync_a: assert property (detect_start_out == field_window_start_out)
    else $error("window start differs");
  card_irq_a: assert property (detect_done_in && card_found_in |=> card_irq_out)
    else $error("card irq missing");
  power_down_a: assert property (
    power_down_out |-> $past(detect_done_in) && !$past(card_found_in))
    else $error("power down without cause");
  irq_sticky_a: assert property (irq_flag_out |=> irq_flag_out)
    else $error("irq flag dropped");
  trim_irq_a: assert property (trim_start_out |-> irq_flag_out)
    else $error("trim without underflow");
  wake_pulse_a: assert property (wake_system_out |=> !wake_system_out)
    else $error("wake pulse too long");
  run_rise_a: assert property (
    $rose(active_out) |-> $past(bus_in.wr) && $past(bus_in.wdata[6]))
    else $error("run without strobe");
  ctrl_read_a: assert property (
    ctrl_rd |=> rdata_out[7] == $past(active_out) && !rdata_out[6])
    else $error("control readback wrong");
  unmapped_rd_a: assert property (bad_rd |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
endmodule : wkt_timer_assertions
bind wkt_timer wkt_timer_assertions #(.CNT_W(CNT_W)) u_chk (.clk_in(clk_in), .nrst_in(nrst_in),
  .bus_in(bus_in), .rdata_out(rdata_out), .slow_osc_in(slow_osc_in),
  .detect_done_in(detect_done_in), .card_found_in(card_found_in),
  .wake_system_out(wake_system_out), .irq_flag_out(irq_flag_out),
  .trim_start_out(trim_start_out), .detect_start_out(detect_start_out),
  .field_window_start_out(field_window_start_out), .card_irq_out(card_irq_out),
  .power_down_out(power_down_out), .active_out(active_out));

// >>> test/wkt_timer_tb.sv
/* Self-checking bench for wkt_timer.
   Assumes the bench alone drives every input. */
`timescale 1ns/1ns
module wkt_timer_tb;
  import wkt_pkg::*;
  logic         clk_in, nrst_in, osc, done, found, rd_q;
  logic         wake, irq, trim, det, cirq, pdn, act;
  wkt_bus_req_t bus;
  logic [7:0]   rdata;
  logic [7:0]   rdq[$], evq[$];
  logic [15:0]  rv;
  int           error_cnt = 0, tests_run = 0;
  wkt_timer DUT (.clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus), .rdata_out(rdata),
    .slow_osc_in(osc), .detect_done_in(done), .card_found_in(found), .wake_system_out(wake),
    .irq_flag_out(irq), .trim_start_out(trim), .detect_start_out(det),
    .field_window_start_out(), .card_irq_out(cirq), .power_down_out(pdn), .active_out(act));
  initial begin
    clk_in = 0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic stop_test();
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    bus = '{w, !w, a, d};
    if (!w) rdq.push_back(d);
    @(negedge clk_in);
    bus = '0;
  endtask : acc
  task automatic pulses(input int n);
    repeat (n) begin
      @(negedge clk_in) osc = 1'b1;
      repeat (6) @(negedge clk_in);
      osc = 1'b0;
      repeat (6) @(negedge clk_in);
    end
  endtask : pulses
  task automatic finish_detect(input logic c);
    @(negedge clk_in);
    done = 1'b1;
    found = c;
    @(negedge clk_in);
    done = 1'b0;
  endtask : finish_detect
  always @(posedge clk_in) rd_q <= bus.rd;
  // Oldest note against each result
  always @(negedge clk_in) begin
    if (rd_q === 1'b1) cmp(rdata, rdq.pop_front());
    if ({wake, trim, det, cirq, pdn} !== 5'h00)
      cmp({3'h0, wake, trim, det, cirq, pdn}, evq.pop_front());
  end
  initial begin
    #500000;
    error_cnt++;
    stop_test();
  end
  initial begin
    bus = '0; osc = 0; done = 0; found = 0; rd_q = 0; nrst_in = 0;
    void'($urandom(32'h62fc));
    repeat (16) @(negedge clk_in);
    nrst_in = 1;
    acc(0, 8'h23, 8'h00);
    acc(1, 8'h24, 8'h12); acc(1, 8'h25, 8'h34); acc(1, 8'h23, 8'hC0);
    acc(1, 8'h24, 8'hAB); acc(1, 8'h25, 8'hCD); acc(0, 8'h26, 8'h12);
    acc(0, 8'h27, 8'h34);
    acc(0, 8'h25, 8'hCD);
    acc(1, 8'h23, 8'h08); acc(0, 8'h23, 8'h88);
    acc(1, 8'h26, 8'h00); acc(0, 8'h26, 8'h12);
    acc(0, 8'h30, 8'h00);
    for (int s = 0; s < 4; s++) begin
      rv = 16'($urandom_range(16'hFFFF, 3));
      acc(1, 8'h24, rv[15:8]); acc(1, 8'h25, rv[7:0]); acc(1, 8'h23, 8'hC0 | 8'(s));
      pulses(s == 0 ? 2 : 8 << s);
      acc(0, 8'h27, 8'(rv - 16'd2));
      acc(0, 8'h26, 8'((rv - 16'd2) >> 8));
    end
    acc(1, 8'h24, 8'h00); acc(1, 8'h25, 8'h02); acc(1, 8'h23, 8'hE4);
    evq.push_back(8'h18);
    pulses(3);
    cmp({7'h0, irq}, 8'h01);
    cmp({7'h0, act}, 8'h00);
    acc(0, 8'h23, 8'h24);
    acc(1, 8'h25, 8'h01); acc(1, 8'h23, 8'hDC);
    evq.push_back(8'h14);
    pulses(2);
    cmp({7'h0, act}, 8'h01);
    acc(0, 8'h27, 8'h01);
    acc(0, 8'h23, 8'h9C);
    evq.push_back(8'h01);
    finish_detect(1'b0);
    evq.push_back(8'h02);
    finish_detect(1'b1);
    acc(1, 8'h23, 8'h40); acc(0, 8'h23, 8'h00);
    repeat (4) @(negedge clk_in);
    cmp(8'(rdq.size() + evq.size()), 8'h00);
    stop_test();
  end
endmodule : wkt_timer_tb
